// file: hdl/icp_pkg.sv
// constants shared by the serial configuration port, its register bank and the alarm monitors
// assumes a single device clock; every pin-side input is synchronised before use
package icp_pkg;
    // serial target address: fixed upper bits, low two bits from the select pins
    localparam logic [4:0] DEV_ADDR_HI = 5'h1B;
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // register bank
    localparam int NUM_REGS = 24;
    localparam logic [7:0] REG_QTYPE0 = 8'h12;
    localparam logic [7:0] REG_QTYPE1 = 8'h13;
    localparam logic [7:0] REG_GLOBAL = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h17;
    localparam logic [7:0] GLOBAL_RST = 8'h04;
    localparam logic [7:0] REG_RST = 8'h00;

    // field positions
    localparam int QTYPE_BIT = 0;
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int CFG_BIT = 5;
    localparam int CFG_SRC_BIT = 4;
    localparam int OE_BIT = 2;
    localparam int ST_HOLD_BIT = 6;
    localparam int ST_REFBAD_BIT = 4;
    localparam int ST_XTALBAD_BIT = 3;
    localparam int ST_LOCK_BIT = 2;

    // operating modes
    localparam logic [1:0] MODE_SYNTH = 2'h0;
    localparam logic [1:0] MODE_HBW = 2'h1;
    localparam logic [1:0] MODE_LBW = 2'h2;

    // feedback edges without a reference edge before the alarm rises
    localparam logic [1:0] FB_MISS_LAST = 2'h2;

    // synchroniser lanes
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_XTAL = 2;
    localparam int SY_FBUP = 3;
    localparam int SY_FBLOW = 4;
    localparam int SY_REF = 5;
    localparam int SY_LOCK = 6;
    localparam int SY_RVALID = 7;
    localparam int SY_OEPIN = 8;
    localparam int SY_CFGPIN = 9;
    localparam int SY_A0 = 10;
    localparam int SY_A1 = 11;
    localparam int SYNC_W = 12;

    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ACK_ADDR = 9'h004,
        ST_PTR      = 9'h008,
        ST_ACK_PTR  = 9'h010,
        ST_WDATA    = 9'h020,
        ST_ACK_W    = 9'h040,
        ST_RDATA    = 9'h080,
        ST_ACK_R    = 9'h100
    } icp_state_t;
endpackage : icp_pkg

// file: hdl/icp_regmem.sv
// byte-wide register bank with one write port and a registered read port
// assumes writes and reads come from the serial engine on the same clock
`timescale 1ns/1ps
module icp_regmem
    import icp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic [7:0] status_i,
    output logic [7:0] rd_data_o,
    output logic [7:0] qtype0_o,
    output logic [7:0] qtype1_o,
    output logic [7:0] global_o
);
    logic [7:0] mem_reg [NUM_REGS];
    logic [7:0] rd_data_next;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_entry
            localparam logic [7:0] IDX = 8'(gi);
            localparam logic [7:0] RST = (IDX == REG_GLOBAL) ? GLOBAL_RST : REG_RST;
            logic [7:0] entry_next;
            // the status entry only mirrors live state, so software writes never land there
            always_comb begin
                if (IDX == REG_STATUS) begin
                    entry_next = status_i;
                end else if (wr_en_i && wr_addr_i == IDX) begin
                    entry_next = wr_data_i;
                end else begin
                    entry_next = mem_reg[gi];
                end
            end
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mem_reg[gi] <= RST;
                end else begin
                    mem_reg[gi] <= entry_next;
                end
            end
        end
    endgenerate

    // reads past the bank return zero
    always_comb begin
        rd_data_next = 8'h00;
        if (rd_addr_i < 8'(NUM_REGS)) begin
            rd_data_next = mem_reg[rd_addr_i[4:0]];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= rd_data_next;
        end
    end

    assign qtype0_o = mem_reg[REG_QTYPE0[4:0]];
    assign qtype1_o = mem_reg[REG_QTYPE1[4:0]];
    assign global_o = mem_reg[REG_GLOBAL[4:0]];
endmodule : icp_regmem

// file: hdl/icp_edge_mon.sv
// missing-edge monitor: counts feedback edges since the last reference edge
// assumes both edge inputs are single-cycle pulses already in the device clock domain
`timescale 1ns/1ps
module icp_edge_mon
    import icp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ref_edge_i,
    input wire logic fb_edge_i,
    output logic alarm_o
);
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic alarm_next;

    always_comb begin
        cnt_next = cnt_reg;
        alarm_next = alarm_o;
        // a reference edge wins over a coincident feedback edge and clears at once
        if (ref_edge_i) begin
            cnt_next = 2'h0;
            alarm_next = 1'b0;
        end else if (fb_edge_i) begin
            if (cnt_reg == FB_MISS_LAST) begin
                alarm_next = 1'b1;
            end else begin
                cnt_next = 2'(cnt_reg + 2'h1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 2'h0;
            alarm_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            alarm_o <= alarm_next;
        end
    end
endmodule : icp_edge_mon

// file: hdl/icp_top.sv
// serial configuration port, register bank, alarm monitors and output-enable gating
// assumes scl/sda and all analog-side signals are asynchronous to ref_clk_i;
// scl must stay well below a quarter of the device clock rate
// Function
// - answer only address 11011 plus select pins
// - write: address, pointer, data bytes, each acknowledged
// - first written byte loads the register pointer
// - bytes ascend from pointer, msb first
// - read: repeated start, read address, device sends
// - master may stop after any whole byte
// - driver enabled only when bit and pin enabled
// - enable bit resets to enabled
// - disabled output pair goes high impedance
// - active configuration's bit picks output standard
// - three feedback edges without crystal edge alarm
// - crystal edge clears crystal alarm immediately
// - three feedback edges without reference edge alarm
// - reference check feedback follows bandwidth mode
// - lock flag follows frequency lock, low on reference loss
// - every alarm on a pin and status bit
// - no-valid-reference bit when not locked to reference
// - reference loss stops adjustment, holdover or free-run; in synthesizer mode neither holdover nor free-run is flagged
// - recovered reference resumes tracking automatically
// - two-bit mode field steers alarm detector
`timescale 1ns/1ps
module icp_top
    import icp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_select_low_i,
    input wire logic addr_select_high_i,
    input wire logic oe_pin_i,
    input wire logic config_pin_i,
    input wire logic xtal_edge_i,
    input wire logic upper_fb_edge_i,
    input wire logic lower_fb_edge_i,
    input wire logic ref_div_edge_i,
    input wire logic freq_locked_i,
    input wire logic ref_valid_i,
    output logic crystal_edges_missing_o,
    output logic ref_edges_missing_o,
    output logic pll_locked_flag_o,
    output logic no_valid_ref_o,
    output logic phase_adjust_en_o,
    output logic holdover_o,
    output logic free_run_o,
    output logic out_enable_o,
    output logic out_hiz_o,
    output logic out_lvds_o,
    output logic config_sel_o,
    output logic [1:0] mode_sel_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic [SYNC_W-1:0] dly_reg;
    logic [SYNC_W-1:0] rise;
    logic [SYNC_W-1:0] fall;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    logic [SYNC_W-1:0] pins;
    assign pins = {addr_select_high_i, addr_select_low_i, config_pin_i, oe_pin_i, ref_valid_i,
                   freq_locked_i, ref_div_edge_i, lower_fb_edge_i, upper_fb_edge_i,
                   xtal_edge_i, sda_i, scl_i};

    genvar gs;
    generate
        for (gs = 0; gs < SYNC_W; gs++) begin : g_sync
            // idle-high reset keeps a released bus from looking like a start
            always_ff @(posedge ref_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg[gs] <= 1'b1;
                    sync_reg[gs] <= 1'b1;
                    dly_reg[gs] <= 1'b1;
                end else begin
                    meta_reg[gs] <= pins[gs];
                    sync_reg[gs] <= meta_reg[gs];
                    dly_reg[gs] <= sync_reg[gs];
                end
            end
            assign rise[gs] = sync_reg[gs] & ~dly_reg[gs];
            assign fall[gs] = ~sync_reg[gs] & dly_reg[gs];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // register bank
    logic wr_en;
    logic [7:0] byte_in;
    logic [7:0] rd_data;
    logic [7:0] qtype0;
    logic [7:0] qtype1;
    logic [7:0] global_bits;
    logic [7:0] status_bits;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;

    icp_regmem u_regmem (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .wr_en_i(wr_en),
        .wr_addr_i(ptr_reg),
        .wr_data_i(byte_in),
        .rd_addr_i(ptr_reg),
        .status_i(status_bits),
        .rd_data_o(rd_data),
        .qtype0_o(qtype0),
        .qtype1_o(qtype1),
        .global_o(global_bits)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // serial engine: samples on scl rise, changes sda on scl fall
    icp_state_t state_reg;
    icp_state_t state_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic rw_reg;
    logic rw_next;
    logic pull_reg;
    logic pull_next;
    logic slot_reg;
    logic slot_next;
    logic nack_reg;
    logic nack_next;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic sda_s;
    logic [6:0] own_addr;

    assign sda_s = sync_reg[SY_SDA];
    assign scl_rise = rise[SY_SCL];
    assign scl_fall = fall[SY_SCL];
    assign start_det = fall[SY_SDA] & sync_reg[SY_SCL];
    assign stop_det = rise[SY_SDA] & sync_reg[SY_SCL];
    assign own_addr = {DEV_ADDR_HI, sync_reg[SY_A1], sync_reg[SY_A0]};
    assign byte_in = {shift_reg[6:0], sda_s};

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        pull_next = pull_reg;
        slot_next = slot_reg;
        nack_next = nack_reg;
        wr_en = 1'b0;
        if (start_det) begin
            // a repeated start lands here too, keeping the pointer
            state_next = ST_ADDR;
            cnt_next = 3'h0;
            pull_next = 1'b0;
        end else if (stop_det) begin
            state_next = ST_IDLE;
            pull_next = 1'b0;
        end else if (scl_rise) begin
            unique case (state_reg)
                ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA: begin
                    shift_next = byte_in;
                    cnt_next = 3'(cnt_reg + 3'h1);
                    slot_next = 1'b0;
                    if (cnt_reg == BIT_LAST) begin
                        unique case (state_reg)
                            ST_ADDR: begin
                                if (byte_in[7:1] == own_addr) begin
                                    rw_next = byte_in[0];
                                    state_next = ST_ACK_ADDR;
                                end else begin
                                    state_next = ST_IDLE;
                                end
                            end
                            ST_PTR: begin
                                ptr_next = byte_in;
                                state_next = ST_ACK_PTR;
                            end
                            ST_WDATA: begin
                                wr_en = 1'b1;
                                ptr_next = 8'(ptr_reg + 8'h01);
                                state_next = ST_ACK_W;
                            end
                            default: begin
                                state_next = ST_ACK_R;
                            end
                        endcase
                    end
                end
                ST_ACK_R: begin
                    nack_next = sda_s;
                    slot_next = 1'b1;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_reg)
                ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_W: begin
                    if (!slot_reg) begin
                        pull_next = 1'b1;
                        slot_next = 1'b1;
                    end else begin
                        pull_next = 1'b0;
                        cnt_next = 3'h0;
                        if (state_reg == ST_ACK_ADDR && rw_reg) begin
                            state_next = ST_RDATA;
                            tx_next = rd_data;
                            pull_next = ~rd_data[7];
                            ptr_next = 8'(ptr_reg + 8'h01);
                        end else if (state_reg == ST_ACK_ADDR) begin
                            state_next = ST_PTR;
                        end else begin
                            state_next = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    tx_next = {tx_reg[6:0], 1'b0};
                    pull_next = ~tx_reg[6];
                end
                ST_ACK_R: begin
                    if (!slot_reg) begin
                        pull_next = 1'b0;
                    end else if (nack_reg) begin
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_RDATA;
                        cnt_next = 3'h0;
                        tx_next = rd_data;
                        pull_next = ~rd_data[7];
                        ptr_next = 8'(ptr_reg + 8'h01);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            pull_reg <= 1'b0;
            slot_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            pull_reg <= pull_next;
            slot_reg <= slot_next;
            nack_reg <= nack_next;
        end
    end

    // open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = pull_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // alarm monitors
    logic [1:0] mode;
    logic ref_fb_edge;
    logic xtal_alarm;
    logic ref_alarm;

    assign mode = global_bits[MODE_HI_BIT:MODE_LO_BIT];
    // synthesizer mode has no lower loop; the upper feedback keeps the alarm defined
    assign ref_fb_edge = (mode == MODE_LBW) ? rise[SY_FBLOW] : rise[SY_FBUP];

    icp_edge_mon u_xtal_mon (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .ref_edge_i(rise[SY_XTAL]),
        .fb_edge_i(rise[SY_FBUP]),
        .alarm_o(xtal_alarm)
    );

    icp_edge_mon u_ref_mon (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .ref_edge_i(rise[SY_REF]),
        .fb_edge_i(ref_fb_edge),
        .alarm_o(ref_alarm)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // status, holdover and output stage
    logic ref_fail;
    logic active_cfg;
    logic [7:0] flags_next;
    logic [7:0] flags_reg;

    assign ref_fail = ref_alarm | ~sync_reg[SY_RVALID];
    assign active_cfg = global_bits[CFG_SRC_BIT] ? global_bits[CFG_BIT] : sync_reg[SY_CFGPIN];

    always_comb begin
        flags_next = 8'h00;
        flags_next[0] = xtal_alarm;
        flags_next[1] = ref_alarm;
        flags_next[2] = sync_reg[SY_LOCK] & ~ref_fail;
        flags_next[3] = ref_fail;
        flags_next[4] = ~ref_fail;
        flags_next[5] = ref_fail & (mode == MODE_LBW);
        flags_next[6] = ref_fail & (mode == MODE_HBW);
        flags_next[7] = global_bits[OE_BIT] & sync_reg[SY_OEPIN];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= 8'h00;
            out_lvds_o <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            out_lvds_o <= active_cfg ? qtype1[QTYPE_BIT] : qtype0[QTYPE_BIT];
        end
    end

    always_comb begin
        status_bits = 8'h00;
        status_bits[ST_HOLD_BIT] = flags_reg[3];
        status_bits[ST_REFBAD_BIT] = flags_reg[1];
        status_bits[ST_XTALBAD_BIT] = flags_reg[0];
        status_bits[ST_LOCK_BIT] = flags_reg[2];
    end

    assign crystal_edges_missing_o = flags_reg[0];
    assign ref_edges_missing_o = flags_reg[1];
    assign pll_locked_flag_o = flags_reg[2];
    assign no_valid_ref_o = flags_reg[3];
    assign phase_adjust_en_o = flags_reg[4];
    assign holdover_o = flags_reg[5];
    assign free_run_o = flags_reg[6];
    assign out_enable_o = flags_reg[7];
    assign out_hiz_o = ~flags_reg[7];
    assign config_sel_o = active_cfg;
    assign mode_sel_o = mode;
endmodule : icp_top

// file: sim/icp_top_props.sv
// checker: alarm, gating and serial-pin relations
// assumes a bind into icp_top; sees only its ports
`timescale 1ns/1ps
module icp_top_props
    import icp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic oe_pin_i,
    input wire logic xtal_edge_i,
    input wire logic ref_div_edge_i,
    input wire logic freq_locked_i,
    input wire logic crystal_edges_missing_o,
    input wire logic ref_edges_missing_o,
    input wire logic pll_locked_flag_o,
    input wire logic no_valid_ref_o,
    input wire logic phase_adjust_en_o,
    input wire logic holdover_o,
    input wire logic free_run_o,
    input wire logic out_enable_o,
    input wire logic out_hiz_o,
    input wire logic [1:0] mode_sel_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_hiz_inverse: assert property (out_hiz_o != out_enable_o)
        else $error("hiz not inverse of enable");
    a_adjust_stop: assert property ($changed(no_valid_ref_o) |-> phase_adjust_en_o != no_valid_ref_o)
        else $error("adjust not stopped on ref loss");
    // flags lag mode by a cycle; only settled modes are judged
    a_holdover_lbw: assert property (holdover_o && $stable(mode_sel_o)
        |-> no_valid_ref_o && mode_sel_o == MODE_LBW) else $error("holdover outside low-bw");
    a_freerun_hbw: assert property (free_run_o && $stable(mode_sel_o)
        |-> no_valid_ref_o && mode_sel_o == MODE_HBW) else $error("free-run outside high-bw");
    a_lock_valid: assert property (pll_locked_flag_o |-> !no_valid_ref_o)
        else $error("locked without valid ref");
    a_sda_open_drain: assert property (sda_o == 1'b0)
        else $error("sda driven high");
    a_xtal_clear: assert property ($rose(xtal_edge_i) |-> ##[1:8] !crystal_edges_missing_o)
        else $error("xtal alarm not cleared");
    a_ref_clear: assert property ($rose(ref_div_edge_i) |-> ##[1:8] !ref_edges_missing_o)
        else $error("ref alarm not cleared");
    a_oe_pin_off: assert property ($fell(oe_pin_i) |-> ##[1:6] !out_enable_o)
        else $error("enable kept after pin off");
    a_lock_drop: assert property ($fell(freq_locked_i) |-> ##[1:6] !pll_locked_flag_o)
        else $error("lock kept after lock loss");
    c_xtal_alarm: cover property ($rose(crystal_edges_missing_o));
    c_holdover: cover property ($rose(holdover_o));
    c_sda_pull: cover property ($rose(sda_oe_o));
endmodule : icp_top_props

// file: sim/icp_i2c_master.sv
// serial bus master: start, stop and byte slots, 320 ns scl period
// assumes an external pull-up on sda; scl stands still between frames
`timescale 1ns/1ps
module icp_i2c_master (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // also a repeated start; first wait lets a device ack release
    task start();
        #120 sda_low_o = 1'b0;
        #120 scl_o = 1'b1;
        #120 sda_low_o = 1'b1;
        #80 scl_o = 1'b0;
    endtask : start
    task stop();
        #120 sda_low_o = 1'b1;
        #120 scl_o = 1'b1;
        #120 sda_low_o = 1'b0;
        #160;
    endtask : stop
    task bit_x(input logic b, output logic r);
        #80 sda_low_o = !b;
        #80 scl_o = 1'b1;
        #80 r = sda_i;
        #80 scl_o = 1'b0;
    endtask : bit_x
    // msb first, then the ack slot
    task byte_x(input logic [7:0] tx, input logic ack_i, output logic [7:0] rx,
                output logic ack_o);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(ack_i, ack_o);
    endtask : byte_x
endmodule : icp_i2c_master

// file: sim/testbench.sv
// self-checking bench: serial transfers, alarms and output gating
// assumes the master model and a pull-up on sda
`timescale 1ns/1ps
module testbench;
    import icp_pkg::*;
    logic clk, nrst, oe_pin, cfg_pin, locked, ref_ok, scl, m_low, sda_oe, sda_d, ack;
    logic crys, refm, lock_f, nvr, padj, hold, frun, oe_o, hiz, lvds, cfg_sel;
    logic [3:0] edg;
    logic [1:0] asel, mode;
    logic [7:0] rx;
    logic [7:0] rbuf [3];
    int n_errors = 0, comparisons = 0, cycles = 0;
    wire sda = !(m_low || sda_oe);

    icp_i2c_master master (.sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
    icp_top dut (.ref_clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_d),
        .sda_oe_o(sda_oe), .addr_select_low_i(asel[0]), .addr_select_high_i(asel[1]),
        .oe_pin_i(oe_pin), .config_pin_i(cfg_pin), .xtal_edge_i(edg[0]),
        .upper_fb_edge_i(edg[1]), .lower_fb_edge_i(edg[2]), .ref_div_edge_i(edg[3]),
        .freq_locked_i(locked), .ref_valid_i(ref_ok), .crystal_edges_missing_o(crys),
        .ref_edges_missing_o(refm), .pll_locked_flag_o(lock_f), .no_valid_ref_o(nvr),
        .phase_adjust_en_o(padj), .holdover_o(hold), .free_run_o(frun),
        .out_enable_o(oe_o), .out_hiz_o(hiz), .out_lvds_o(lvds), .config_sel_o(cfg_sel),
        .mode_sel_o(mode));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task end_sim();
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk
    task header(input logic rd);
        master.start();
        master.byte_x({DEV_ADDR_HI, asel, rd}, 1'b1, rx, ack);
        check("addr ack", ack, 1'b0);
    endtask : header
    task write_block(input logic [7:0] ptr, input int n);
        header(1'b0);
        master.byte_x(ptr, 1'b1, rx, ack);
        check("ptr ack", ack, 1'b0);
        for (int i = 0; i < n; i++) begin
            master.byte_x(rbuf[i], 1'b1, rx, ack);
            check("data ack", ack, 1'b0);
        end
        master.stop();
        wait_clk(2);
    endtask : write_block
    task read_block(input logic [7:0] ptr, input int n);
        header(1'b0);
        master.byte_x(ptr, 1'b1, rx, ack);
        header(1'b1);
        for (int i = 0; i < n; i++) begin
            master.byte_x(8'hFF, i == n - 1, rbuf[i], ack);
        end
        master.stop();
        wait_clk(2);
    endtask : read_block
    // four-cycle phases outlast the synchroniser
    task pulse(input int i, input int n);
        repeat (n) begin
            edg[i] = 1'b1;
            wait_clk(4);
            edg[i] = 1'b0;
            wait_clk(4);
        end
        wait_clk(4);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        oe_pin = 1'b1;
        cfg_pin = 1'b0;
        locked = 1'b0;
        ref_ok = 1'b1;
        edg = 4'h0;
        asel = 2'b10;
        wait_clk(12);
        nrst = 1'b1;
        wait_clk(16);
        check("oe", oe_o, 1'b1);
        check("hiz", hiz, 1'b0);
        check("mode", mode, MODE_SYNTH);
        for (int i = 0; i < 2; i++) begin
            master.start();
            master.byte_x(i ? {DEV_ADDR_HI, 2'b01, 1'b0} : 8'hB0, 1'b1, rx, ack);
            check("foreign ack", ack, 1'b1);
            master.byte_x(REG_GLOBAL, 1'b1, rx, ack);
            check("ignored ack", ack, 1'b1);
            master.stop();
        end
        rbuf = '{8'h00, 8'h01, 8'h70};
        write_block(REG_QTYPE0, 3);
        check("mode", mode, MODE_HBW);
        check("config", cfg_sel, 1'b1);
        check("lvds", lvds, 1'b1);
        check("oe", oe_o, 1'b0);
        check("hiz", hiz, 1'b1);
        rbuf = '{default: 8'h55};
        read_block(REG_QTYPE0, 3);
        check("rd 18", rbuf[0], 8'h00);
        check("rd 19", rbuf[1], 8'h01);
        check("rd 20", rbuf[2], 8'h70);
        pulse(1, 2);
        check("xtal", crys, 1'b0);
        pulse(1, 1);
        check("xtal", crys, 1'b1);
        check("ref", refm, 1'b1);
        check("no ref", nvr, 1'b1);
        check("free run", frun, 1'b1);
        check("holdover", hold, 1'b0);
        check("adjust", padj, 1'b0);
        read_block(REG_STATUS, 1);
        check("status", rbuf[0], 8'h58);
        pulse(0, 1);
        check("xtal", crys, 1'b0);
        pulse(3, 1);
        check("ref", refm, 1'b0);
        check("adjust", padj, 1'b1);
        check("free run", frun, 1'b0);
        locked = 1'b1;
        wait_clk(8);
        check("lock", lock_f, 1'b1);
        ref_ok = 1'b0;
        wait_clk(8);
        check("lock", lock_f, 1'b0);
        check("no ref", nvr, 1'b1);
        ref_ok = 1'b1;
        wait_clk(8);
        check("lock", lock_f, 1'b1);
        locked = 1'b0;
        wait_clk(8);
        check("lock", lock_f, 1'b0);
        rbuf[0] = 8'h84;
        write_block(REG_GLOBAL, 1);
        check("mode", mode, MODE_LBW);
        check("lvds", lvds, 1'b0);
        check("oe", oe_o, 1'b1);
        cfg_pin = 1'b1;
        wait_clk(8);
        check("lvds", lvds, 1'b1);
        pulse(1, 3);
        check("ref", refm, 1'b0);
        pulse(2, 3);
        check("ref", refm, 1'b1);
        check("holdover", hold, 1'b1);
        pulse(3, 1);
        check("holdover", hold, 1'b0);
        oe_pin = 1'b0;
        wait_clk(8);
        check("oe", oe_o, 1'b0);
        end_sim();
    end
endmodule : testbench

bind icp_top icp_top_props u_props (.ref_clk_i, .nrst_i, .sda_o, .sda_oe_o, .oe_pin_i,
    .xtal_edge_i, .ref_div_edge_i, .freq_locked_i, .crystal_edges_missing_o,
    .ref_edges_missing_o, .pll_locked_flag_o, .no_valid_ref_o, .phase_adjust_en_o,
    .holdover_o, .free_run_o, .out_enable_o, .out_hiz_o, .mode_sel_o);
